// ==== ipsc_pkg.sv ====
`default_nettype none
package ipsc_pkg;
   // address byte: fixed prefix, two select bits, write bit
   localparam logic [4:0] ADDR_PREFIX = 5'h08;
   localparam logic [1:0] ADDR_SEL_GND = 2'h2;
   localparam logic [1:0] ADDR_SEL_VS = 2'h3;
   localparam logic ADDR_WRITE = 1'h0;
   // bit counter values inside one byte slot
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_END = 4'h9;
   localparam logic [3:0] BIT_ZERO = 4'h0;
   // data byte fields
   localparam int TYPE_BIT = 7;
   localparam int PUMP_BIT = 6;
   localparam int MUTE_HI = 5;
   localparam int MUTE_LO = 3;
   localparam int TEST_HI = 2;
   localparam int TEST_LO = 0;
   localparam int DIVH_HI = 5;
   localparam int DIVH_LO = 0;
   localparam int DIVL_HI = 7;
   localparam int DIVL_LO = 3;
   localparam int DIV_W = 11;
   // latch reset values: ratio 1024, control normal with all outputs on
   localparam logic [7:0] DIVH_RESET = 8'h20;
   localparam logic [7:0] DIVL_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h80;
   localparam logic [DIV_W-1:0] DIV_RESET = 11'h400;
   // test codes for the detector pin
   localparam logic [2:0] TEST_REF = 3'h4;
   localparam logic [2:0] TEST_DIV = 3'h6;
   localparam logic [2:0] TEST_TRI = 3'h7;
   localparam logic [2:0] TEST_FLOAT = 3'h3;
   // crystal 4 MHz divided to the 10 kHz reference
   localparam int REF_DIV = 400;
   localparam int REF_CNT_W = 9;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_DATA = 4'h4,
      ST_IGN = 4'h8
   } ipsc_state_type;
endpackage
`default_nettype wire

// ==== ipsc_top.sv ====
// Functional notes
// R1 - oscillator is divided by programmable N, 1024 to 2047, before comparison.
// R2 - 10 kHz reference comes from the 4 MHz crystal divided by 400.
// R3 - divided oscillator edge first: source pulse lasts exactly until reference edge.
// R4 - reference edge first: sink pulse lasts until the divided oscillator edge.
// R5 - edges in phase: no pump pulse, output floats, loop is locked.
// R6 - software bit picks low or high pump current, ratio one to five.
// R7 - idle bus rests high; transfer starts when data falls with clock high.
// R8 - master changes data only while clock low; device samples rising clock.
// R9 - data rising while clock high is a stop ending the transfer.
// R10 - device holds data low through the ninth clock as acknowledge.
// R11 - first byte is prefix 01000, two select bits, write bit low.
// R12 - select pin grounded answers 0x44; tied high or open answers 0x46.
// R13 - top bit of a data byte: zero starts divider pair, one control.
// R14 - master follows first divider byte with its second, or stops.
// R15 - divider bytes carry n10..n5 after two zeros, then n4..n0, three zeros.
// R16 - control byte: one, pump select, three mute bits, three test bits.
// R17 - test codes route reference, divided oscillator, or float detector pins.
// R18 - mute code disables audio outputs per channel; disabled outputs float.
// R19 - after power up the device pulls the data line low only to acknowledge.
// R20 - received bytes land in three latches: two divider bytes, control.
// R21 - data line is only pulled low or released; pull-up gives high.
// R22 - telegram: address alone, divider pair, control, or both either order.
// R23 - wrong address or read bit: no acknowledge, rest of telegram ignored.
// R24 - new ratio reaches the divider only after both bytes acknowledged.
`timescale 1ns/1ps
`default_nettype none
module ipsc_top
   import ipsc_pkg::*;
#(
   parameter int REF_DIV_P = REF_DIV
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic vco_clk,
   input wire logic xtal_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic addr_select_pin,
   output logic phase_detector_out,
   output logic phase_detector_oe,
   output logic integrator_oe,
   output logic pump_up,
   output logic pump_dn,
   output logic pump_current_select,
   output logic [2:0] af_out_en
);
   localparam logic [REF_CNT_W-1:0] REF_LAST = REF_CNT_W'(REF_DIV_P - 1);
   localparam logic [REF_CNT_W-1:0] REF_HALF = REF_CNT_W'(REF_DIV_P / 2);

   // pin synchronisers: stage 1 feeds stage 2 only, stage 3 is history
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic sel_s1, sel_s2;
   logic xt_s1, xt_s2, xt_s3;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_s3 <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_s3 <= 1'b1;
         sel_s1 <= 1'b1;
         sel_s2 <= 1'b1;
         xt_s1 <= 1'b0;
         xt_s2 <= 1'b0;
         xt_s3 <= 1'b0;
      end else begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_s3 <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_s3 <= sda_s2;
         sel_s1 <= addr_select_pin;
         sel_s2 <= sel_s1;
         xt_s1 <= xtal_in;
         xt_s2 <= xt_s1;
         xt_s3 <= xt_s2;
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s2 & ~scl_s3;
   assign scl_fall = ~scl_s2 & scl_s3;
   assign start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2; // R7
   assign stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2; // R9

   ipsc_state_type st_q;
   logic [3:0] cnt_q;
   logic [7:0] shift_q;
   logic [7:0] byte_in;
   logic [7:0] my_addr;
   logic ack_start, ack_end;

   assign byte_in = {shift_q[6:0], sda_s2};
   // open pin reads high, so an unwired select gives the upper address
   assign my_addr = {ADDR_PREFIX, sel_s2 ? ADDR_SEL_VS : ADDR_SEL_GND, ADDR_WRITE}; // R11 R12
   assign ack_start = scl_fall && cnt_q == BIT_ACK;
   assign ack_end = scl_fall && cnt_q == BIT_END;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_q <= ST_IDLE;
         cnt_q <= BIT_ZERO;
         shift_q <= 8'h00;
      end else if (start_det) begin
         st_q <= ST_ADDR; // R7
         cnt_q <= BIT_ZERO;
      end else if (stop_det) begin
         st_q <= ST_IDLE; // R9
         cnt_q <= BIT_ZERO;
      end else begin
         case (st_q)
            ST_ADDR, ST_DATA: begin
               if (scl_rise && cnt_q < BIT_ACK) begin
                  shift_q <= byte_in; // R8
                  cnt_q <= cnt_q + 4'h1;
                  if (st_q == ST_ADDR && cnt_q == BIT_LAST && byte_in != my_addr) begin
                     st_q <= ST_IGN; // R23
                  end
               end else if (ack_start) begin
                  cnt_q <= BIT_END;
               end else if (ack_end) begin
                  cnt_q <= BIT_ZERO;
                  st_q <= ST_DATA;
               end
            end
            ST_IGN: begin
               cnt_q <= BIT_ZERO;
            end
            ST_IDLE: begin
               cnt_q <= BIT_ZERO;
            end
            default: begin
               st_q <= ST_IDLE;
               cnt_q <= BIT_ZERO;
            end
         endcase
      end
   end

   // acknowledge: pull low from the fall after bit 8 to the fall after bit 9
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sda_oe <= 1'b0; // R19
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0; // R21
         if (start_det || stop_det) begin
            sda_oe <= 1'b0;
         end else if (ack_start && (st_q == ST_ADDR || st_q == ST_DATA)) begin
            sda_oe <= 1'b1; // R10
         end else if (ack_end || st_q == ST_IGN || st_q == ST_IDLE) begin
            sda_oe <= 1'b0;
         end
      end
   end

   // holding latches; the pair is committed only when the second byte is acked
   logic [7:0] div_hi_q, div_lo_q, ctrl_q;
   logic pend_q, commit_q, req_tgl_q;
   logic [DIV_W-1:0] div_ratio_q;
   logic data_done;
   assign data_done = ack_end && st_q == ST_DATA && !start_det && !stop_det;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_hi_q <= DIVH_RESET;
         div_lo_q <= DIVL_RESET;
         ctrl_q <= CTRL_RESET;
         pend_q <= 1'b0;
         commit_q <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         if (start_det || stop_det) begin
            pend_q <= 1'b0; // R14
         end else if (data_done) begin
            if (pend_q) begin
               div_lo_q <= shift_q; // R15 R20
               pend_q <= 1'b0;
               commit_q <= 1'b1; // R24
            end else if (!shift_q[TYPE_BIT]) begin
               div_hi_q <= shift_q; // R13 R20
               pend_q <= 1'b1;
            end else begin
               ctrl_q <= shift_q; // R13 R16 R20
            end
         end
      end
   end

   // the word stays still for many bus clocks, far longer than the crossing
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_ratio_q <= DIV_RESET;
         req_tgl_q <= 1'b0;
      end else if (commit_q) begin
         div_ratio_q <= {div_hi_q[DIVH_HI:DIVH_LO], div_lo_q[DIVL_HI:DIVL_LO]}; // R15 R24
         req_tgl_q <= ~req_tgl_q;
      end
   end

   // oscillator domain: reset released in step with vco_clk
   logic vrst_s1, vrst_n;
   always_ff @(posedge vco_clk or negedge arst_n) begin
      if (!arst_n) begin
         vrst_s1 <= 1'b0;
         vrst_n <= 1'b0;
      end else begin
         vrst_s1 <= 1'b1;
         vrst_n <= vrst_s1;
      end
   end

   logic rq_s1, rq_s2, rq_s3;
   logic [DIV_W-1:0] n_vco_q, vcnt_q;
   logic osc_div_q;

   always_ff @(posedge vco_clk or negedge vrst_n) begin
      if (!vrst_n) begin
         rq_s1 <= 1'b0;
         rq_s2 <= 1'b0;
         rq_s3 <= 1'b0;
         n_vco_q <= DIV_RESET;
      end else begin
         rq_s1 <= req_tgl_q;
         rq_s2 <= rq_s1;
         rq_s3 <= rq_s2;
         if (rq_s2 != rq_s3) begin
            n_vco_q <= div_ratio_q;
         end
      end
   end

   always_ff @(posedge vco_clk or negedge vrst_n) begin
      if (!vrst_n) begin
         vcnt_q <= '0;
         osc_div_q <= 1'b1;
      end else begin
         if (vcnt_q >= n_vco_q - 11'h001) begin
            vcnt_q <= '0; // R1
         end else begin
            vcnt_q <= vcnt_q + 11'h001;
         end
         osc_div_q <= vcnt_q < (n_vco_q >> 1); // R1
      end
   end

   // back to the system clock: divided oscillator and crystal reference
   logic dv_s1, dv_s2, dv_s3;
   logic [REF_CNT_W-1:0] ref_cnt_q;
   logic ref_q, ref_prev_q;
   logic xtal_rise, div_fall, ref_fall;
   assign xtal_rise = xt_s2 & ~xt_s3;
   assign div_fall = dv_s3 & ~dv_s2;
   assign ref_fall = ref_prev_q & ~ref_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dv_s1 <= 1'b1;
         dv_s2 <= 1'b1;
         dv_s3 <= 1'b1;
      end else begin
         dv_s1 <= osc_div_q;
         dv_s2 <= dv_s1;
         dv_s3 <= dv_s2;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ref_cnt_q <= '0;
         ref_q <= 1'b1;
         ref_prev_q <= 1'b1;
      end else begin
         ref_prev_q <= ref_q;
         if (xtal_rise) begin
            if (ref_cnt_q == REF_LAST) begin
               ref_cnt_q <= '0; // R2
            end else begin
               ref_cnt_q <= ref_cnt_q + 9'h001;
            end
            ref_q <= ref_cnt_q < REF_HALF;
         end
      end
   end

   // tri-state frequency/phase detector on falling edges
   logic up_q, dn_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         up_q <= 1'b0;
         dn_q <= 1'b0;
      end else if ((up_q | div_fall) & (dn_q | ref_fall)) begin
         up_q <= 1'b0; // R5
         dn_q <= 1'b0;
      end else begin
         up_q <= up_q | div_fall; // R3
         dn_q <= dn_q | ref_fall; // R4
      end
   end

   logic [2:0] test_code;
   assign test_code = ctrl_q[TEST_HI:TEST_LO];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_detector_out <= 1'b0;
         phase_detector_oe <= 1'b0;
         integrator_oe <= 1'b1;
         pump_up <= 1'b0;
         pump_dn <= 1'b0;
      end else begin
         pump_up <= up_q;
         pump_dn <= dn_q;
         integrator_oe <= test_code != TEST_FLOAT; // R17
         case (test_code)
            TEST_REF: begin
               phase_detector_out <= ref_q; // R17
               phase_detector_oe <= 1'b1;
            end
            TEST_DIV: begin
               phase_detector_out <= dv_s2; // R17
               phase_detector_oe <= 1'b1;
            end
            TEST_TRI, TEST_FLOAT: begin
               phase_detector_out <= 1'b0; // R17
               phase_detector_oe <= 1'b0;
            end
            default: begin
               // high sources, low sinks, floating when locked
               phase_detector_out <= up_q; // R3 R4
               phase_detector_oe <= up_q ^ dn_q; // R5
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pump_current_select <= 1'b0;
         af_out_en <= 3'h7;
      end else begin
         pump_current_select <= ctrl_q[PUMP_BIT]; // R6
         // bit 2 mutes channel one, bit 0 channel three
         af_out_en <= ~ctrl_q[MUTE_HI:MUTE_LO]; // R18
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_start_addr;
      start_det |=> st_q == ST_ADDR && cnt_q == BIT_ZERO;
   endproperty
   a_start_addr: assert property (p_start_addr) else $error("start missed"); // R7

   property p_sample;
      (scl_rise && !start_det && !stop_det && cnt_q < BIT_ACK && st_q == ST_DATA)
         |=> shift_q[0] == $past(sda_s2) && cnt_q == $past(cnt_q) + 4'h1;
   endproperty
   a_sample: assert property (p_sample) else $error("bit not sampled"); // R8

   property p_stop_idle;
      stop_det |=> st_q == ST_IDLE && !sda_oe && !pend_q;
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured"); // R9

   property p_ack_drive;
      (ack_start && st_q == ST_DATA && !start_det && !stop_det)
         |=> sda_oe && cnt_q == BIT_END;
   endproperty
   a_ack_drive: assert property (p_ack_drive) else $error("no acknowledge"); // R10

   property p_ack_window;
      sda_oe |-> cnt_q == BIT_END;
   endproperty
   a_ack_window: assert property (p_ack_window) else $error("data held low late"); // R10

   property p_ignore;
      st_q == ST_IGN |-> !sda_oe;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ack on foreign address"); // R23

   property p_up;
      (div_fall && !ref_fall && !dn_q) |=> up_q && !dn_q;
   endproperty
   a_up: assert property (p_up) else $error("source pulse missing"); // R3

   property p_dn;
      (ref_fall && !div_fall && !up_q) |=> dn_q && !up_q;
   endproperty
   a_dn: assert property (p_dn) else $error("sink pulse missing"); // R4

   property p_lock;
      (div_fall && ref_fall) |=> !up_q && !dn_q ##1 !phase_detector_oe || test_code != 3'h0;
   endproperty
   a_lock: assert property (p_lock) else $error("pulse while in phase"); // R5

   property p_ref_wrap;
      (xtal_rise && ref_cnt_q == REF_LAST) |=> ref_cnt_q == '0;
   endproperty
   a_ref_wrap: assert property (p_ref_wrap) else $error("reference count wrong"); // R2

   property p_commit;
      commit_q |=> div_ratio_q == $past({div_hi_q[DIVH_HI:DIVH_LO], div_lo_q[DIVL_HI:DIVL_LO]});
   endproperty
   a_commit: assert property (p_commit) else $error("ratio not applied"); // R24

   property p_ratio_hold;
      !commit_q |=> $stable(div_ratio_q);
   endproperty
   a_ratio_hold: assert property (p_ratio_hold) else $error("ratio changed early"); // R24

   property p_mute;
      $changed(ctrl_q) |=> af_out_en == ~$past(ctrl_q[MUTE_HI:MUTE_LO]);
   endproperty
   a_mute: assert property (p_mute) else $error("mute code ignored"); // R18

   c_addr_ack: cover property (st_q == ST_ADDR && ack_start);
   c_commit: cover property (commit_q);
   c_ctrl: cover property (data_done && !pend_q && shift_q[TYPE_BIT]);
   c_lock: cover property (div_fall && ref_fall);
endmodule
`default_nettype wire

// ==== ipsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ipsc_host_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // bus idles with both lines released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   // also serves as repeated start: data released before clock rises
   task automatic start_c();
      sda_low = 1'b0;
      tick(6);
      scl = 1'b1;
      tick(6);
      sda_low = 1'b1;
      tick(6);
      scl = 1'b0;
      tick(6);
   endtask
   task automatic stop_c();
      sda_low = 1'b1;
      tick(6);
      scl = 1'b1;
      tick(6);
      sda_low = 1'b0;
      tick(8);
   endtask
   // ack is taken only if the line reads low both two and six clocks into the high phase
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = ~b[i];
         tick(4);
         scl = 1'b1;
         tick(6);
         scl = 1'b0;
         tick(4);
      end
      sda_low = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(2);
      ack = ~sda_line;
      tick(4);
      ack = ack & ~sda_line;
      scl = 1'b0;
      tick(4);
   endtask
endmodule
`default_nettype wire

// ==== i2c_pll_synth_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module i2c_pll_synth_control_bench;
   import ipsc_pkg::*;
   localparam int REFD = 8;
   logic clk, arst_n, vco_clk, xtal_in, scl, host_low, addr_select_pin;
   logic sda_out, sda_oe, pd_out, pd_oe, int_oe, pump_up, pump_dn, pump_sel;
   logic [2:0] af_out_en;
   logic sda_wire;
   int err_count, samples_checked;
   assign sda_wire = !((sda_oe && !sda_out) || host_low);
   ipsc_top #(.REF_DIV_P(REFD)) u_ipsc_top (.clk(clk), .arst_n(arst_n), .vco_clk(vco_clk),
      .xtal_in(xtal_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
      .addr_select_pin(addr_select_pin), .phase_detector_out(pd_out),
      .phase_detector_oe(pd_oe), .integrator_oe(int_oe), .pump_up(pump_up),
      .pump_dn(pump_dn), .pump_current_select(pump_sel), .af_out_en(af_out_en));
   ipsc_host_model u_ipsc_host_model (.clk(clk), .sda_line(sda_wire), .scl(scl),
      .sda_low(host_low));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // oscillator and crystal clocks run unrelated to clk
   initial begin
      vco_clk = 1'b0;
      #7;
      forever #40 vco_clk = ~vco_clk;
   end
   initial begin
      xtal_in = 1'b0;
      #3;
      forever #125 xtal_in = ~xtal_in;
   end
   task automatic summarize();
      if (err_count == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   function automatic logic [7:0] ctrl(input logic p, input logic [2:0] m, input logic [2:0] t);
      return {1'b1, p, m, t};
   endfunction
   task automatic wr(input logic [7:0] b, input logic exp_ack);
      logic a;
      u_ipsc_host_model.send_byte(b, a);
      check("ack", {31'h0, a}, {31'h0, exp_ack});
   endtask
   task automatic set_ctrl(input logic [7:0] c);
      u_ipsc_host_model.start_c();
      wr(8'h44, 1'b1);
      wr(c, 1'b1);
      u_ipsc_host_model.stop_c();
   endtask
   task automatic set_div(input logic [10:0] n, input logic both);
      u_ipsc_host_model.start_c();
      wr(8'h44, 1'b1);
      wr({2'b00, n[10:5]}, 1'b1);
      if (both) begin
         wr({n[4:0], 3'b000}, 1'b1);
      end
      u_ipsc_host_model.stop_c();
   endtask
   // period of the detector pin in units of the given step, in ns
   task automatic period(input real step, output int units);
      real t[2];
      int n;
      n = 0;
      for (int k = 0; k < 3; k++) begin
         while (pd_out !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
         end
         while (pd_out !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
         end
         if (k > 0) begin
            t[k-1] = $realtime;
         end
      end
      if (n >= 40000) begin
         err_count++;
         summarize();
      end
      units = $rtoi((t[1] - t[0]) / step + 0.5);
   endtask
   initial begin
      logic [2:0] m, tc[5];
      logic p;
      logic [10:0] n1, n2;
      int u, both_hi, dn_seen;
      tc = '{3'h3, 3'h7, 3'h4, 3'h0, 3'h6};
      err_count = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      addr_select_pin = 1'b0;
      void'($urandom(32'h7db1ef2a));
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      check("af_rst", {29'h0, af_out_en}, 32'h7);
      check("int_oe_rst", {31'h0, int_oe}, 32'h1);
      check("sda_oe_rst", {31'h0, sda_oe}, 32'h0);
      check("pump_rst", {31'h0, pump_sel}, 32'h0);
      for (int i = 0; i < 8; i++) begin
         m = 3'($urandom);
         p = 1'($urandom);
         if (i == 0) m = 3'h7;
         set_ctrl(ctrl(p, m, 3'h0));
         check("af_en", {29'h0, af_out_en}, {29'h0, ~m});
         check("pump_sel", {31'h0, pump_sel}, {31'h0, p});
      end
      n1 = 11'(1024 + ($urandom % 1024));
      n2 = 11'(1024 + ($urandom % 1024));
      set_div(n1, 1'b1);
      foreach (tc[i]) begin
         set_ctrl(ctrl(1'b0, 3'h0, tc[i]));
         check("int_oe", {31'h0, int_oe}, {31'h0, tc[i] != 3'h3});
         if (tc[i] == 3'h3 || tc[i] == 3'h7) begin
            check("pd_oe", {31'h0, pd_oe}, 32'h0);
         end
         if (tc[i] == 3'h4) begin
            period(250.0, u);
            check("ref_period", u, REFD);
         end
         if (tc[i] == 3'h0) begin
            both_hi = 0;
            dn_seen = 0;
            repeat (4000) begin
               @(negedge clk);
               both_hi += int'(pump_up === 1'b1 && pump_dn === 1'b1);
               dn_seen |= int'(pump_dn === 1'b1);
            end
            check("pump_overlap", both_hi, 0);
            check("pump_dn", dn_seen, 1);
         end
      end
      period(80.0, u);
      check("div_period", u, {21'h0, n1});
      set_div(n2, 1'b0);
      period(80.0, u);
      check("div_lone", u, {21'h0, n1});
      u_ipsc_host_model.start_c();
      wr(8'h44, 1'b1);
      wr(ctrl(1'b1, 3'h0, 3'h6), 1'b1);
      wr({2'b00, n2[10:5]}, 1'b1);
      wr({n2[4:0], 3'b000}, 1'b1);
      u_ipsc_host_model.stop_c();
      period(80.0, u);
      check("div_pair", u, {21'h0, n2});
      addr_select_pin = 1'b1;
      u_ipsc_host_model.tick(6);
      u_ipsc_host_model.start_c();
      wr(8'h44, 1'b0);
      wr(ctrl(1'b0, 3'h7, 3'h0), 1'b0);
      u_ipsc_host_model.start_c();
      wr(8'h47, 1'b0);
      wr(ctrl(1'b0, 3'h7, 3'h0), 1'b0);
      u_ipsc_host_model.stop_c();
      check("af_ignored", {29'h0, af_out_en}, 32'h7);
      u_ipsc_host_model.start_c();
      wr(8'h46, 1'b1);
      wr(ctrl(1'b0, 3'h5, 3'h0), 1'b1);
      u_ipsc_host_model.stop_c();
      check("sda_out", {31'h0, sda_out}, 32'h0);
      check("af_sel_hi", {29'h0, af_out_en}, 32'h2);
      summarize();
   end
endmodule
`default_nettype wire
